// ==== rtl/bss_top.sv ====
// bss_top: boot source selection with nv configuration bits behind an axi4-lite slave
// assumes one clock, synchronous straps, and that the fast-programming command engine sits outside
`timescale 1ns/10ps
`include "bss_defines.svh"

// Overview of operation
// - three nv configuration bits are each set or cleared by a command word through the flash controller interface.
// - every reset starts fetch at address zero, whose contents depend on the boot selection bit.
// - nv bit 1 set maps flash at address zero, clear maps rom there.
// - the erase pin clears nv bit 1 so the next boot comes from rom.
// - the rom boot program sits at address zero whenever nv bit 1 read zero at the one sample taken after the last reset release.
// - rom is the default boot source; flash boot needs the bit set explicitly.
// - test strap and port a lines 0 and 1 all low enable the fast programming port and mode.
// - in fast programming mode the read, program, erase, full erase, lock, unlock and protect commands are accepted on serial or parallel port.
//   here only the fast_flash_prog_port enable is driven; the engine that accepts those commands sits outside.
module bss_top
    import bss_pkg::*;
(
    input  wire logic        aclk,              // 20 MHz clock
    input  wire logic        aresetn,           // synchronous reset, active low
    input  wire logic [11:0] s_axi_awaddr,      // write address
    input  wire logic        s_axi_awvalid,     // write address valid
    output logic             s_axi_awready,     // write address ready
    input  wire logic [31:0] s_axi_wdata,       // write data
    input  wire logic [3:0]  s_axi_wstrb,       // write strobes
    input  wire logic        s_axi_wvalid,      // write data valid
    output logic             s_axi_wready,      // write data ready
    output logic [1:0]       s_axi_bresp,       // write response
    output logic             s_axi_bvalid,      // write response valid
    input  wire logic        s_axi_bready,      // write response ready
    input  wire logic [11:0] s_axi_araddr,      // read address
    input  wire logic        s_axi_arvalid,     // read address valid
    output logic             s_axi_arready,     // read address ready
    output logic [31:0]      s_axi_rdata,       // read data
    output logic [1:0]       s_axi_rresp,       // read response
    output logic             s_axi_rvalid,      // read data valid
    input  wire logic        s_axi_rready,      // read data ready
    input  wire logic        nv_init_valid,     // power-up load of nv image
    input  wire bss_pkg::bss_nv_t nv_init_bits, // nv image from array
    input  wire logic        erase_pin,         // erase pin, active high
    input  wire logic        test_strap_pin,    // test strap
    input  wire logic        port_a_line_zero,  // strap line 0
    input  wire logic        port_a_line_one,   // strap line 1
    output logic [31:0]      boot_fetch_addr,   // first fetch address after reset
    output logic             boot_from_flash,   // address zero maps flash
    output logic             boot_from_rom,     // address zero maps rom
    output logic             fast_flash_prog_port, // fast programming port enabled
    output logic             security_flag      // nv bit 0
);
    logic     aw_got_r, aw_got_nxt;
    logic     w_got_r, w_got_nxt;
    logic [11:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic     bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic     rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic     awready_r, wready_r, arready_r;
    logic     bad_cmd_r, bad_cmd_nxt;
    logic     flash_r, rom_r, ffp_r, sec_r;
    logic [31:0] fetch_r;

    bss_op_t  op;
    logic [1:0] op_idx;
    bss_nv_t  nv_bits;
    bss_src_t boot_src;
    logic     ffp_mode;
    logic     captured;
    logic     wr_fire;
    logic [7:0] cmd_key, cmd_op, cmd_idx;

    bss_nv_store bss_nv_store_inst (
        .aclk       (aclk),
        .init_valid (nv_init_valid),
        .init_bits  (nv_init_bits),
        .op         (op),
        .op_idx     (op_idx),
        .erase_pin  (erase_pin),
        .nv_bits    (nv_bits)
    );

    bss_boot_latch bss_boot_latch_inst (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .boot_bit         (nv_bits[`BSS_BIT_BOOT]),
        .test_strap_pin   (test_strap_pin),
        .port_a_line_zero (port_a_line_zero),
        .port_a_line_one  (port_a_line_one),
        .boot_src         (boot_src),
        .ffp_mode         (ffp_mode),
        .captured         (captured)
    );

    // write channel: address and data taken in either order, response after both
    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    assign cmd_key = w_data_r[`BSS_CMD_KEY_POS +: 8];
    assign cmd_op  = w_data_r[`BSS_CMD_OP_POS +: 8];
    assign cmd_idx = w_data_r[`BSS_CMD_IDX_POS +: 8];

    // a command word needs the key so a stray write cannot flip boot selection
    always_comb begin
        op          = BSS_OP_NONE;
        op_idx      = cmd_idx[1:0];
        bad_cmd_nxt = bad_cmd_r;
        bresp_nxt   = bresp_r;
        if (wr_fire) begin
            bresp_nxt = `BSS_RESP_OKAY;
            if (aw_addr_r[11:2] != 10'(`BSS_OFF_CMD >> 2)) begin
                bresp_nxt = `BSS_RESP_SLVERR;
            end else if (w_strb_r != 4'hf || cmd_key != `BSS_CMD_KEY
                         || cmd_idx >= 8'(`BSS_NV_BITS)) begin
                bad_cmd_nxt = 1'b1;
                bresp_nxt   = `BSS_RESP_SLVERR;
            end else if (cmd_op == `BSS_OP_SET) begin
                op          = BSS_OP_SET_BIT;
                bad_cmd_nxt = 1'b0;
            end else if (cmd_op == `BSS_OP_CLR) begin
                op          = BSS_OP_CLR_BIT;
                bad_cmd_nxt = 1'b0;
            end else begin
                bad_cmd_nxt = 1'b1;
                bresp_nxt   = `BSS_RESP_SLVERR;
            end
        end
    end

    always_comb begin
        aw_got_nxt  = aw_got_r;
        aw_addr_nxt = aw_addr_r;
        w_got_nxt   = w_got_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        if (s_axi_awvalid && awready_r) begin
            aw_got_nxt  = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_got_nxt  = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_fire) begin
            bvalid_nxt = 1'b1;
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // read channel: one read in flight, answer one cycle after the address is taken
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `BSS_RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            unique case (s_axi_araddr[11:2])
                10'(`BSS_OFF_CMD >> 2): rdata_nxt = 32'h0000_0000;
                10'(`BSS_OFF_STAT >> 2): begin
                    rdata_nxt[`BSS_NV_BITS-1:0]  = nv_bits;
                    rdata_nxt[`BSS_STAT_BAD_POS]  = bad_cmd_r;
                    rdata_nxt[`BSS_STAT_FFP_POS]  = ffp_mode;
                    rdata_nxt[`BSS_STAT_BOOT_POS] = boot_src;
                end
                10'(`BSS_OFF_MAP >> 2): rdata_nxt = fetch_r;
                default: rresp_nxt = `BSS_RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r  <= 1'b0;
            aw_addr_r <= 12'h000;
            w_got_r   <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `BSS_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `BSS_RESP_OKAY;
            bad_cmd_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            arready_r <= 1'b0;
        end else begin
            aw_got_r  <= aw_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_got_r   <= w_got_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            bad_cmd_r <= bad_cmd_nxt;
            // readies stay low while a half is held or a response waits
            awready_r <= !aw_got_nxt && !bvalid_nxt && !(s_axi_awvalid && awready_r);
            wready_r  <= !w_got_nxt && !bvalid_nxt && !(s_axi_wvalid && wready_r);
            arready_r <= !rvalid_nxt && !(s_axi_arvalid && arready_r);
        end
    end

    // mapping outputs register the latched choice; rom until the sample is
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_r <= 1'b0;
            rom_r   <= 1'b1;
            ffp_r   <= 1'b0;
            sec_r   <= 1'b0;
            fetch_r <= `BSS_BOOT_ADDR;
        end else begin
            flash_r <= captured && boot_src == BSS_SRC_FLASH;
            rom_r   <= !(captured && boot_src == BSS_SRC_FLASH);
            // the command engine itself is outside; this enable gates it
            ffp_r   <= captured && ffp_mode;
            sec_r   <= nv_bits[`BSS_BIT_SECURE];
            fetch_r <= `BSS_BOOT_ADDR;
        end
    end

    assign s_axi_awready   = awready_r;
    assign s_axi_wready    = wready_r;
    assign s_axi_bvalid    = bvalid_r;
    assign s_axi_bresp     = bresp_r;
    assign s_axi_arready   = arready_r;
    assign s_axi_rvalid    = rvalid_r;
    assign s_axi_rdata     = rdata_r;
    assign s_axi_rresp     = rresp_r;
    assign boot_fetch_addr = fetch_r;
    assign boot_from_flash = flash_r;
    assign boot_from_rom   = rom_r;
    assign fast_flash_prog_port = ffp_r;
    assign security_flag   = sec_r;
endmodule

// ==== rtl/bss_defines.svh ====
// bss_defines.svh: register offsets, field positions, reset values and codes for the boot source select block
// assumes inclusion by bare name from the package and the modules
`ifndef BSS_DEFINES_SVH
`define BSS_DEFINES_SVH

`define BSS_OFF_CMD      12'h000
`define BSS_OFF_STAT     12'h004
`define BSS_OFF_MAP      12'h008
`define BSS_CMD_KEY_POS  24
`define BSS_CMD_KEY      8'h5a
`define BSS_CMD_OP_POS   8
`define BSS_CMD_IDX_POS  0
`define BSS_OP_SET       8'h01
`define BSS_OP_CLR       8'h02
`define BSS_NV_BITS      3
`define BSS_NV_RST       3'h0
`define BSS_BIT_SECURE   0
`define BSS_BIT_BOOT     1
`define BSS_BOOT_ADDR    32'h0000_0000
`define BSS_STAT_BAD_POS 8
`define BSS_STAT_FFP_POS 16
`define BSS_STAT_BOOT_POS 17
`define BSS_RESP_OKAY    2'h0
`define BSS_RESP_SLVERR  2'h2

`endif

// ==== rtl/bss_pkg.sv ====
// bss_pkg: types shared by the boot source select modules
// assumes bss_defines.svh is on the include path
`include "bss_defines.svh"
package bss_pkg;
    typedef enum logic [1:0] {
        BSS_OP_NONE = 2'b00,
        BSS_OP_SET_BIT = 2'b01,
        BSS_OP_CLR_BIT = 2'b10
    } bss_op_t;

    typedef enum logic {
        BSS_SRC_ROM   = 1'b0,
        BSS_SRC_FLASH = 1'b1
    } bss_src_t;

    typedef logic [`BSS_NV_BITS-1:0] bss_nv_t;
endpackage

// ==== rtl/bss_nv_store.sv ====
// bss_nv_store: the non-volatile configuration bit cells
// assumes the surrounding memory keeps these cells across power; here reset does not touch them
`timescale 1ns/10ps
`include "bss_defines.svh"
module bss_nv_store
    import bss_pkg::*;
(
    input  wire logic             aclk,       // system clock
    input  wire logic             init_valid, // one-cycle load of the whole image at power-up
    input  wire bss_pkg::bss_nv_t init_bits,  // image from the backing array
    input  wire bss_pkg::bss_op_t op,         // set or clear one bit
    input  wire logic [1:0]       op_idx,     // index of the bit
    input  wire logic             erase_pin,  // erase pin level
    output bss_pkg::bss_nv_t      nv_bits     // current bit values
);
    bss_nv_t bits_r;
    bss_nv_t bits_nxt;

    // the cells are not reset: their value survives every reset
    always_comb begin
        bits_nxt = bits_r;
        if (init_valid) begin
            bits_nxt = init_bits;
        end
        for (int i = 0; i < `BSS_NV_BITS; i++) begin
            if (op_idx == i[1:0] && op == BSS_OP_SET_BIT) begin
                bits_nxt[i] = 1'b1;
            end
            if (op_idx == i[1:0] && op == BSS_OP_CLR_BIT) begin
                bits_nxt[i] = 1'b0;
            end
        end
        // erase beats a same-cycle set so the next boot is guaranteed from rom
        if (erase_pin) begin
            bits_nxt[`BSS_BIT_BOOT] = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        bits_r <= bits_nxt;
    end

    assign nv_bits = bits_r;
endmodule

// ==== rtl/bss_boot_latch.sv ====
// bss_boot_latch: samples boot selection and straps once after reset release
// assumes straps are synchronous to aclk
`timescale 1ns/10ps
module bss_boot_latch
    import bss_pkg::*;
(
    input  wire logic              aclk,        // system clock
    input  wire logic              aresetn,     // synchronous reset, active low
    input  wire logic              boot_bit,    // nv boot selection bit
    input  wire logic              test_strap_pin,   // test strap level
    input  wire logic              port_a_line_zero, // strap line 0
    input  wire logic              port_a_line_one,  // strap line 1
    output bss_pkg::bss_src_t      boot_src,    // held address-zero source
    output logic                   ffp_mode,    // fast programming mode held
    output logic                   captured     // sample taken since reset
);
    bss_src_t src_r, src_nxt;
    logic     ffp_r, ffp_nxt;
    logic     cap_r, cap_nxt;

    // one capture on the first edge after release, then frozen until reset
    always_comb begin
        src_nxt = src_r;
        ffp_nxt = ffp_r;
        cap_nxt = cap_r;
        if (!cap_r) begin
            src_nxt = boot_bit ? BSS_SRC_FLASH : BSS_SRC_ROM;
            ffp_nxt = ~test_strap_pin & ~port_a_line_zero & ~port_a_line_one;
            cap_nxt = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_r <= BSS_SRC_ROM;
            ffp_r <= 1'b0;
            cap_r <= 1'b0;
        end else begin
            src_r <= src_nxt;
            ffp_r <= ffp_nxt;
            cap_r <= cap_nxt;
        end
    end

    assign boot_src = src_r;
    assign ffp_mode = ffp_r;
    assign captured = cap_r;
endmodule

// ==== testbench/bss_checker.sv ====
// bss_checker: port timing of the boot source select top
// assumes it is bound onto bss_top; one clock, synchronous active-low reset
`timescale 1ns/10ps
module bss_checker (
    input wire logic        aclk,                // clock
    input wire logic        aresetn,             // reset
    input wire logic        s_axi_awvalid,       // aw valid
    input wire logic        s_axi_awready,       // aw ready
    input wire logic        s_axi_wvalid,        // w valid
    input wire logic        s_axi_wready,        // w ready
    input wire logic        s_axi_bvalid,        // b valid
    input wire logic        s_axi_bready,        // b ready
    input wire logic        s_axi_arvalid,       // ar valid
    input wire logic        s_axi_arready,       // ar ready
    input wire logic [31:0] s_axi_rdata,         // read data
    input wire logic        s_axi_rvalid,        // r valid
    input wire logic        s_axi_rready,        // r ready
    input wire logic        erase_pin,           // erase
    input wire logic        test_strap_pin,      // strap
    input wire logic        port_a_line_zero,    // strap
    input wire logic        port_a_line_one,     // strap
    input wire logic [31:0] boot_fetch_addr,     // fetch address
    input wire logic        boot_from_flash,     // flash mapped
    input wire logic        boot_from_rom,       // rom mapped
    input wire logic        fast_flash_prog_port // fast prog
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_map; boot_from_rom == !boot_from_flash; endproperty
    a_map: assert property (p_map) else $error("rom and flash mapping not exclusive");
    property p_fetch; boot_fetch_addr == 32'h0; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address not zero");
    // first edge after reset: nothing latched yet, so rom and no fast mode
    property p_dflt; $past(!aresetn) |-> boot_from_rom && !fast_flash_prog_port; endproperty
    a_dflt: assert property (p_dflt) else $error("reset mapping not rom");
    property p_hold;
        aresetn && $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3)
            |-> $stable(boot_from_flash) && $stable(fast_flash_prog_port);
    endproperty
    a_hold: assert property (p_hold) else $error("mapping changed between resets");
    property p_ffp;
        aresetn && $past(aresetn, 2) && !$past(aresetn, 3) |-> fast_flash_prog_port ==
            !($past(test_strap_pin, 2) | $past(port_a_line_zero, 2) | $past(port_a_line_one, 2));
    endproperty
    a_ffp: assert property (p_ffp) else $error("fast mode does not follow straps");
    property p_erase;
        aresetn && $past(aresetn, 2) && !$past(aresetn, 3) && $past(erase_pin, 2) && $past(erase_pin, 3)
            |-> boot_from_rom;
    endproperty
    a_erase: assert property (p_erase) else $error("erase did not force rom boot");
    // both halves taken at one edge: the response is registered one cycle after the held pair fires
    property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_bans: assert property (p_bans) else $error("write response late");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read response late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
endmodule
bind bss_top bss_checker bss_checker_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .erase_pin(erase_pin), .test_strap_pin(test_strap_pin),
    .port_a_line_zero(port_a_line_zero), .port_a_line_one(port_a_line_one), .boot_fetch_addr(boot_fetch_addr),
    .boot_from_flash(boot_from_flash), .boot_from_rom(boot_from_rom), .fast_flash_prog_port(fast_flash_prog_port));

// ==== testbench/bss_pin_model.sv ====
// bss_pin_model: board straps and erase pin on the far side of the block
// assumes the bench asks for levels; pins follow one edge later, as a board would settle
`timescale 1ns/10ps
module bss_pin_model (
    input  wire logic       aclk,                    // clock
    input  wire logic [2:0] strap_req,               // wanted {strap, line1, line0}
    input  wire logic       erase_req,               // wanted erase level
    output logic            test_strap_pin = 1'h1,   // test strap
    output logic            port_a_line_zero = 1'h1, // strap line 0
    output logic            port_a_line_one = 1'h1,  // strap line 1
    output logic            erase_pin = 1'h0         // erase, active high
);
    // board drives all three low only to ask for fast programming
    always @(posedge aclk) begin
        {test_strap_pin, port_a_line_one, port_a_line_zero} <= strap_req;
        erase_pin <= erase_req;
    end
endmodule

// ==== testbench/tb_boot_source_select.sv ====
// tb_boot_source_select: self-checking bench for bss_top
// assumes bss_pin_model drives straps and erase; nv image is loaded once at power-up
`timescale 1ns/10ps
`include "bss_defines.svh"
module tb_boot_source_select;
    import bss_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        init_v = 0, erase_req = 0, awready, wready, bvalid, arready, rvalid;
    logic        tst, pa0, pa1, erase, flash, rom, ffp, sec;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, fetch;
    logic [3:0]  wstrb = 0;
    logic [1:0]  bresp, rresp, exp_b[$];
    logic [2:0]  strap_req = 3'h7, nv = 0;
    logic [33:0] exp_r[$];
    logic [7:0]  idx, op;
    logic        bt;
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    bss_top bss_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nv_init_valid(init_v),
        .nv_init_bits(3'h0), .erase_pin(erase), .test_strap_pin(tst), .port_a_line_zero(pa0),
        .port_a_line_one(pa1), .boot_fetch_addr(fetch), .boot_from_flash(flash), .boot_from_rom(rom),
        .fast_flash_prog_port(ffp), .security_flag(sec));
    bss_pin_model bss_pin_model_inst (.aclk(aclk), .strap_req(strap_req), .erase_req(erase_req),
        .test_strap_pin(tst), .port_a_line_zero(pa0), .port_a_line_one(pa1), .erase_pin(erase));
    always #25 aclk = ~aclk;
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // monitor: every response is matched against the oldest note
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            give_verdict();
        end
        if (bvalid && bready) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
        if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
    end
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [11:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        @(posedge aclk);
    endtask
    function automatic logic [31:0] cmd(input logic [7:0] o, input logic [7:0] i);
        return {`BSS_CMD_KEY, 8'h00, o, i};
    endfunction
    function automatic logic [33:0] stat(input logic bad, input logic fm, input logic bt);
        return {`BSS_RESP_OKAY, 14'h0, bt, fm, 7'h0, bad, 5'h0, nv};
    endfunction
    task automatic do_reset();
        aresetn <= 1'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
    endtask
    task automatic boot_chk(input logic f, input logic m);
        check({33'h0, flash}, {33'h0, f});
        check({33'h0, rom}, {33'h0, !f});
        check({33'h0, ffp}, {33'h0, m});
        check({2'h0, fetch}, {2'h0, `BSS_BOOT_ADDR});
    endtask
    initial begin
        void'($urandom(32'h5851));
        @(posedge aclk);
        init_v <= 1'h1;
        @(posedge aclk);
        init_v <= 1'h0;
        do_reset();
        boot_chk(1'h0, 1'h0);
        axi_read(`BSS_OFF_STAT, stat(1'h0, 1'h0, 1'h0));
        axi_read(`BSS_OFF_MAP, {2'h0, `BSS_BOOT_ADDR});
        $display("test default boot done");
        axi_write(`BSS_OFF_CMD, cmd(`BSS_OP_SET, 8'h01), 4'hf, `BSS_RESP_OKAY);
        nv[1] = 1'h1;
        boot_chk(1'h0, 1'h0);
        do_reset();
        boot_chk(1'h1, 1'h0);
        axi_read(`BSS_OFF_STAT, stat(1'h0, 1'h0, 1'h1));
        $display("test flash boot done");
        repeat (8) begin
            idx = 8'($urandom_range(2, 0));
            op = $urandom_range(1, 0) ? `BSS_OP_SET : `BSS_OP_CLR;
            axi_write(`BSS_OFF_CMD, cmd(op, idx), 4'hf, `BSS_RESP_OKAY);
            nv[idx[1:0]] = (op == `BSS_OP_SET);
            axi_read(`BSS_OFF_STAT, stat(1'h0, 1'h0, 1'h1));
        end
        axi_write(`BSS_OFF_CMD, cmd(`BSS_OP_SET, 8'h00), 4'hf, `BSS_RESP_OKAY);
        nv[0] = 1'h1;
        repeat (2) @(posedge aclk);
        check({33'h0, sec}, {33'h0, 1'h1});
        do_reset();
        check({33'h0, sec}, {33'h0, 1'h1});
        boot_chk(nv[1], 1'h0);
        bt = nv[1];
        $display("test set and clear done");
        axi_write(`BSS_OFF_STAT, cmd(`BSS_OP_SET, 8'h01), 4'hf, `BSS_RESP_SLVERR);
        axi_read(12'h00c, {`BSS_RESP_SLVERR, 32'h0});
        axi_write(`BSS_OFF_CMD, {8'h5a ^ 8'($urandom_range(255, 1)), 16'h0101}, 4'hf, `BSS_RESP_SLVERR);
        axi_read(`BSS_OFF_STAT, stat(1'h1, 1'h0, nv[1]));
        axi_write(`BSS_OFF_CMD, cmd(8'h03, 8'h01), 4'hf, `BSS_RESP_SLVERR);
        axi_write(`BSS_OFF_CMD, cmd(`BSS_OP_SET, 8'h03), 4'hf, `BSS_RESP_SLVERR);
        axi_write(`BSS_OFF_CMD, cmd(`BSS_OP_SET, 8'h01), 4'h7, `BSS_RESP_SLVERR);
        axi_read(`BSS_OFF_STAT, stat(1'h1, 1'h0, nv[1]));
        axi_write(`BSS_OFF_CMD, cmd(`BSS_OP_SET, 8'h01), 4'hf, `BSS_RESP_OKAY);
        nv[1] = 1'h1;
        axi_read(`BSS_OFF_STAT, stat(1'h0, 1'h0, bt));
        $display("test refused commands done");
        erase_req <= 1'h1;
        do_reset();
        erase_req <= 1'h0;
        nv[1] = 1'h0;
        boot_chk(1'h0, 1'h0);
        axi_read(`BSS_OFF_STAT, stat(1'h0, 1'h0, 1'h0));
        $display("test erase done");
        for (int m = 0; m < 8; m++) begin
            strap_req <= m[2:0];
            do_reset();
            boot_chk(1'h0, m == 0);
            if (m == 0) axi_read(`BSS_OFF_STAT, stat(1'h0, 1'h1, 1'h0));
        end
        $display("test straps done");
        give_verdict();
    end
endmodule
